// ---- hdl/sdst_ctrl.sv ----
// SDRAM command sequencer with self refresh and timing guards
`timescale 1ns/1ps
`include "sdst_defs.svh"
`default_nettype none

module sdst_ctrl #(
  parameter int REF_WINDOW_NS = `SDST_REF_WINDOW_NS,
  parameter int CLK_STABLE_CYC = `SDST_CLK_STABLE_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire sdst_pkg::sdst_req_s REQ,
  output logic SD_CLK,
  output sdst_pkg::sdst_pins_s SD_PINS,
  output logic SELF_REFRESH,
  output logic REFRESH_BUSY
);

  // Longest spacing between refreshes, rounded down
  localparam int REF_INT = REF_WINDOW_NS / `SDST_ROWS / `SDST_CLK_NS;
  localparam logic [11:0] REF_INT_M1 = 12'(REF_INT - 1);

  sdst_pkg::sdst_state_e state_r, state_nxt;
  sdst_pkg::sdst_pins_s pins_r, pins_nxt;
  logic ph_r, clk_run_r, clk_run_nxt;
  logic [3:0] open_r, open_nxt;
  logic [1:0] owed_r, owed_nxt;
  logic [11:0] ref_cnt_r;
  logic [3:0] rp_z, rc_z, rcd_z, rasmin_z, rasmax_z;
  logic [3:0] act_b, pre_b;
  logic rrd_z, rfc_z, sr_z, seq_z, xsr_z;

  // Pins change as SD_CLK falls, so they settle before its rise
  wire slot = ph_r;
  wire in_run = (state_r == sdst_pkg::ST_RUN);
  wire [3:0] expired = open_r & rasmax_z;
  wire [3:0] closable = open_r & rasmin_z;
  wire force_pre = |expired;
  wire need_ref = (owed_r != 2'h0);
  wire all_idle = (open_r == 4'h0) && (&rp_z) && rfc_z;
  wire [1:0] rb = REQ.bank;
  wire ref_tick = in_run && (ref_cnt_r == 12'h000);

  function automatic logic [1:0] low_idx(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (v[i])
        idx = 2'(i);
    return idx;
  endfunction

  wire ok_act = !open_r[rb] && rp_z[rb] && rc_z[rb] && rrd_z && rfc_z;
  wire ok_rw = open_r[rb] && rcd_z[rb];
  wire ok_pre = !open_r[rb] || rasmin_z[rb];
  wire ok_pre_all = ((open_r & ~rasmin_z) == 4'h0);

  wire user_ok =
    (REQ.kind == sdst_pkg::K_ACT) ? ok_act :
    (REQ.kind == sdst_pkg::K_READ) ? ok_rw :
    (REQ.kind == sdst_pkg::K_WRITE) ? ok_rw :
    (REQ.kind == sdst_pkg::K_PRE) ? ok_pre :
    (REQ.kind == sdst_pkg::K_PRE_ALL) ? ok_pre_all :
    (REQ.kind == sdst_pkg::K_SR_ENTER) ? all_idle :
    1'b0;

  wire run_ready = in_run && slot && !force_pre && !need_ref && user_ok;
  wire exit_ready = (state_r == sdst_pkg::ST_SR_HOLD) && sr_z &&
    (REQ.kind == sdst_pkg::K_SR_EXIT);
  assign REQ_READY = run_ready || exit_ready;
  wire accept = REQ_VALID && run_ready;

  wire do_ref = in_run && slot && !force_pre && need_ref && all_idle;
  wire rpre = in_run && slot && !force_pre && need_ref && !all_idle &&
    (|closable);
  wire fpre = in_run && slot && force_pre;
  wire upre = accept && (REQ.kind == sdst_pkg::K_PRE);
  wire upre_all = accept && (REQ.kind == sdst_pkg::K_PRE_ALL);
  wire uact = accept && (REQ.kind == sdst_pkg::K_ACT);
  wire usr = accept && (REQ.kind == sdst_pkg::K_SR_ENTER);
  wire [1:0] pre_bank = fpre ? low_idx(expired) :
    rpre ? low_idx(closable) : rb;
  wire pre_one = fpre || rpre || upre;

  always_comb
  begin
    pins_nxt = pins_r;
    state_nxt = state_r;
    clk_run_nxt = clk_run_r;
    if (slot)
    begin
      pins_nxt.cmd = `SDST_CMD_NOP;
      pins_nxt.ba = 2'h0;
      pins_nxt.addr = 13'h0000;
    end
    case (state_r)
      sdst_pkg::ST_RUN:
      begin
        pins_nxt.cke = 1'b1;
        if (pre_one)
        begin
          pins_nxt.cmd = `SDST_CMD_PRE;
          pins_nxt.ba = pre_bank;
        end
        else if (do_ref)
          pins_nxt.cmd = `SDST_CMD_REF;
        else if (upre_all)
        begin
          pins_nxt.cmd = `SDST_CMD_PRE;
          pins_nxt.addr[`SDST_A10_BIT] = 1'b1;
        end
        else if (usr)
        begin
          pins_nxt.cmd = `SDST_CMD_REF;
          pins_nxt.cke = 1'b0;
          state_nxt = sdst_pkg::ST_SR_ENTER;
        end
        else if (accept)
        begin
          pins_nxt.ba = rb;
          pins_nxt.addr = REQ.addr;
          if (uact)
            pins_nxt.cmd = `SDST_CMD_ACT;
          else
          begin
            // Auto precharge is kept off: burst length is not known here
            pins_nxt.addr[`SDST_A10_BIT] = 1'b0;
            pins_nxt.cmd = (REQ.kind == sdst_pkg::K_READ) ?
              `SDST_CMD_READ : `SDST_CMD_WRITE;
          end
        end
      end
      sdst_pkg::ST_SR_ENTER:
      begin
        // Memory has sampled entry; clock may now stop to save power
        if (slot)
        begin
          clk_run_nxt = 1'b0;
          state_nxt = sdst_pkg::ST_SR_HOLD;
        end
      end
      sdst_pkg::ST_SR_HOLD:
      begin
        pins_nxt.cke = 1'b0;
        if (REQ_VALID && exit_ready)
        begin
          clk_run_nxt = 1'b1;
          state_nxt = sdst_pkg::ST_SR_CLKON;
        end
      end
      sdst_pkg::ST_SR_CLKON:
      begin
        pins_nxt.cke = 1'b0;
        if (slot && seq_z)
        begin
          pins_nxt.cke = 1'b1;
          state_nxt = sdst_pkg::ST_SR_EXIT;
        end
      end
      sdst_pkg::ST_SR_EXIT:
      begin
        pins_nxt.cke = 1'b1;
        if (slot && xsr_z)
          state_nxt = sdst_pkg::ST_RUN;
      end
      default:
      begin
        state_nxt = sdst_pkg::ST_RUN;
        clk_run_nxt = 1'b1;
      end
    endcase
  end

  wire enter_exit = (state_r == sdst_pkg::ST_SR_CLKON) &&
    (state_nxt == sdst_pkg::ST_SR_EXIT);
  wire leave_sr = (state_r == sdst_pkg::ST_SR_EXIT) &&
    (state_nxt == sdst_pkg::ST_RUN);
  wire start_clk = (state_r == sdst_pkg::ST_SR_HOLD) &&
    (state_nxt == sdst_pkg::ST_SR_CLKON);

  // Missed deadline while one is still owed means a wake-up pair
  always_comb
  begin
    owed_nxt = owed_r - {1'b0, do_ref};
    if (leave_sr)
      owed_nxt = 2'(`SDST_WAKE_REFS);
    else if (ref_tick)
      owed_nxt = (owed_nxt == 2'h0) ? 2'h1 : 2'(`SDST_WAKE_REFS);
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_bank
      assign act_b[g] = uact && (rb == 2'(g));
      assign pre_b[g] = upre_all || (pre_one && (pre_bank == 2'(g)));
      assign open_nxt[g] = act_b[g] ? 1'b1 : pre_b[g] ? 1'b0 : open_r[g];
      sdst_cnt u_rasmin (.clk(CLK), .rst_n(RESETN), .load(act_b[g]),
        .value(12'(`SDST_RAS_MIN_CYC)), .zero(rasmin_z[g]));
      sdst_cnt u_rasmax (.clk(CLK), .rst_n(RESETN), .load(act_b[g]),
        .value(12'(`SDST_RAS_MAX_CYC - `SDST_RAS_SLACK_CYC)),
        .zero(rasmax_z[g]));
      sdst_cnt u_rc (.clk(CLK), .rst_n(RESETN), .load(act_b[g]),
        .value(12'(`SDST_RC_CYC)), .zero(rc_z[g]));
      sdst_cnt u_rcd (.clk(CLK), .rst_n(RESETN), .load(act_b[g]),
        .value(12'(`SDST_RCD_CYC)), .zero(rcd_z[g]));
      sdst_cnt u_rp (.clk(CLK), .rst_n(RESETN), .load(pre_b[g]),
        .value(12'(`SDST_RP_CYC)), .zero(rp_z[g]));
    end
  endgenerate

  sdst_cnt u_rrd (.clk(CLK), .rst_n(RESETN), .load(uact),
    .value(12'(`SDST_RRD_CYC)), .zero(rrd_z));
  sdst_cnt u_rfc (.clk(CLK), .rst_n(RESETN), .load(do_ref || usr),
    .value(12'(`SDST_RFC_CYC)), .zero(rfc_z));
  sdst_cnt u_sr (.clk(CLK), .rst_n(RESETN), .load(usr),
    .value(12'(`SDST_SR_MIN_CYC)), .zero(sr_z));
  sdst_cnt u_seq (.clk(CLK), .rst_n(RESETN), .load(start_clk),
    .value(12'(CLK_STABLE_CYC)), .zero(seq_z));
  sdst_cnt u_xsr (.clk(CLK), .rst_n(RESETN), .load(enter_exit),
    .value(12'(`SDST_XSR_CYC)), .zero(xsr_z));

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r <= sdst_pkg::ST_RUN;
      pins_r <= '{cke: 1'b1, cmd: `SDST_CMD_NOP, ba: 2'h0, addr: 13'h0000};
      clk_run_r <= 1'b1;
      ph_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      clk_run_r <= clk_run_nxt;
      ph_r <= clk_run_r ? !ph_r : 1'b0;
    end
  end

  // Wake-up pair also covers the first refreshes after reset
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      open_r <= 4'h0;
      owed_r <= 2'(`SDST_WAKE_REFS);
      ref_cnt_r <= REF_INT_M1;
    end
    else
    begin
      open_r <= open_nxt;
      owed_r <= owed_nxt;
      ref_cnt_r <= (!in_run || ref_tick) ? REF_INT_M1 :
        ref_cnt_r - 12'h001;
    end
  end

  assign SD_CLK = ph_r;
  assign SD_PINS = pins_r;
  assign SELF_REFRESH = !in_run;
  assign REFRESH_BUSY = need_ref;

endmodule // sdst_ctrl

`default_nettype wire

// ---- common/sdst_defs.svh ----
// Timing and encoding constants for the SDRAM self refresh controller
`ifndef SDST_DEFS_SVH
`define SDST_DEFS_SVH

`define SDST_CLK_NS 50
`define SDST_CLK_DIV 2
`define SDST_CYC_UP(ns) (((ns) + `SDST_CLK_NS - 1) / `SDST_CLK_NS)

`define SDST_T_RAS_MIN_NS 50
`define SDST_T_RAS_MAX_NS 120000
`define SDST_T_RC_NS 70
`define SDST_T_RCD_NS 20
`define SDST_T_RRD_NS 20
`define SDST_T_RP_NS 20
`define SDST_T_RFC_NS 70
`define SDST_T_XSR_NS 80
`define SDST_XSR_MIN_CLKS 2

`define SDST_RAS_MIN_CYC `SDST_CYC_UP(`SDST_T_RAS_MIN_NS)
`define SDST_RAS_SLACK_CYC 4
`define SDST_RAS_MAX_CYC (`SDST_T_RAS_MAX_NS / `SDST_CLK_NS)
`define SDST_RC_CYC `SDST_CYC_UP(`SDST_T_RC_NS)
`define SDST_RCD_CYC `SDST_CYC_UP(`SDST_T_RCD_NS)
`define SDST_RRD_CYC `SDST_CYC_UP(`SDST_T_RRD_NS)
`define SDST_RP_CYC `SDST_CYC_UP(`SDST_T_RP_NS)
`define SDST_RFC_CYC `SDST_CYC_UP(`SDST_T_RFC_NS)
`define SDST_SR_MIN_CYC `SDST_CYC_UP(`SDST_T_RAS_MIN_NS)
`define SDST_XSR_RAW_CYC `SDST_CYC_UP(`SDST_T_XSR_NS)
`define SDST_XSR_PIN_CYC (`SDST_XSR_MIN_CLKS * `SDST_CLK_DIV)
`define SDST_XSR_CYC ((`SDST_XSR_RAW_CYC > `SDST_XSR_PIN_CYC) ? \
  `SDST_XSR_RAW_CYC : `SDST_XSR_PIN_CYC)

`define SDST_ROWS 8192
`define SDST_REF_WINDOW_NS 64000000
`define SDST_CLK_STABLE_CYC 8
`define SDST_WAKE_REFS 2

`define SDST_CMD_NOP 4'h7
`define SDST_CMD_ACT 4'h3
`define SDST_CMD_READ 4'h5
`define SDST_CMD_WRITE 4'h4
`define SDST_CMD_PRE 4'h2
`define SDST_CMD_REF 4'h1
`define SDST_A10_BIT 10

`endif

// ---- common/sdst_pkg.sv ----
// Types shared by the SDRAM self refresh controller
`default_nettype none
package sdst_pkg;

  typedef enum logic [2:0] {
    K_ACT = 3'h0,
    K_READ = 3'h1,
    K_WRITE = 3'h2,
    K_PRE = 3'h3,
    K_PRE_ALL = 3'h4,
    K_SR_ENTER = 3'h5,
    K_SR_EXIT = 3'h6
  } sdst_kind_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SR_ENTER = 3'h1,
    ST_SR_HOLD = 3'h2,
    ST_SR_CLKON = 3'h3,
    ST_SR_EXIT = 3'h4
  } sdst_state_e;

  typedef struct packed {
    sdst_kind_e kind;
    logic [1:0] bank;
    logic [12:0] addr;
  } sdst_req_s;

  // cmd is {cs_n, ras_n, cas_n, we_n}
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
  } sdst_pins_s;

endpackage

`default_nettype wire

// ---- hdl/sdst_cnt.sv ----
// Loadable down counter used for command spacing
`timescale 1ns/1ps
`default_nettype none

module sdst_cnt (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [11:0] value,
  output logic zero
);

  logic [11:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 12'h000;
    else if (load)
      cnt_r <= value;
    else if (cnt_r != 12'h000)
      cnt_r <= cnt_r - 12'h001;
  end

  assign zero = (cnt_r == 12'h000);

endmodule // sdst_cnt

`default_nettype wire

// ---- sim/sdst_ctrl_properties.sv ----
// Concurrent checks on the self refresh controller ports
`timescale 1ns/1ps
`default_nettype none

module sdst_ctrl_properties #(
  parameter int REF_WINDOW_NS = 64000000,
  parameter int CLK_STABLE_CYC = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire sdst_pkg::sdst_req_s REQ,
  input wire logic SD_CLK,
  input wire sdst_pkg::sdst_pins_s SD_PINS,
  input wire logic SELF_REFRESH,
  input wire logic REFRESH_BUSY
);
  localparam int IVL = REF_WINDOW_NS / 8192 / 50;
  logic [15:0] gap_r;
  wire sr_take = REQ_VALID && REQ_READY &&
    REQ.kind == sdst_pkg::K_SR_ENTER;
  wire is_ref = SD_PINS.cmd == 4'h1;

  // Cycles since the last refresh, idle while in self refresh
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      gap_r <= 16'h0000;
    else if (SELF_REFRESH || is_ref)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_r + 16'h0001;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  chk_sr_entry_cmd: assert property (
    sr_take |=> !SD_PINS.cke && is_ref) else $error("bad entry");
  chk_ref_cke_mode: assert property (
    is_ref && SD_PINS.cke |-> !SELF_REFRESH) else $error("bad ref");
  chk_cke_low_sr: assert property (
    !SD_PINS.cke |-> SELF_REFRESH) else $error("cke low in run");
  chk_sr_min_hold: assert property (
    $fell(SD_PINS.cke) |-> !SD_PINS.cke [*2]) else $error("short sr");
  chk_clk_before_cke: assert property (
    $rose(SD_PINS.cke) |-> $past(SD_CLK) != $past(SD_CLK, 2))
    else $error("clock not running");
  chk_exit_nops: assert property (
    $rose(SD_PINS.cke) |-> (SD_PINS.cmd == 4'h7) [*4])
    else $error("no exit nops");
  chk_resume_ref: assert property (
    $fell(SELF_REFRESH) |-> REFRESH_BUSY ##[0:12] (is_ref && SD_PINS.cke))
    else $error("no refresh after exit");
  chk_ref_window: assert property (
    gap_r <= 2 * IVL) else $error("refresh late");

  cover property (sr_take);
  cover property ($fell(SELF_REFRESH));
  cover property (SD_PINS.cmd == 4'h3);
endmodule // sdst_ctrl_properties

`default_nettype wire

// ---- sim/sdst_mem_model.sv ----
// Behavioural SDRAM seen from its command pins
`timescale 1ns/1ps
`include "sdst_defs.svh"
`default_nettype none

module sdst_mem_model (
  input wire logic sd_clk,
  input wire sdst_pkg::sdst_pins_s pins,
  output int n_ref,
  output int n_sr,
  output int n_bad,
  output logic in_sr
);
  time t_exit;
  initial
  begin
    n_ref = 0;
    n_sr = 0;
    n_bad = 0;
    in_sr = 1'b0;
    t_exit = 0;
  end
  always @(posedge sd_clk)
  begin
    if (in_sr)
    begin
      // Only clock enable matters here
      if (pins.cke)
      begin
        in_sr <= 1'b0;
        t_exit = $time;
      end
    end
    else if (pins.cmd == `SDST_CMD_REF)
    begin
      if (pins.cke)
        n_ref <= n_ref + 1;
      else
        in_sr <= 1'b1;
    end
    if (!in_sr && t_exit != 0 && pins.cmd != `SDST_CMD_NOP &&
        $time - t_exit < `SDST_T_XSR_NS)
      n_bad <= n_bad + 1;
  end
  // Own refresh timer, no external clock needed
  always #500 if (in_sr) n_sr <= n_sr + 1;
endmodule // sdst_mem_model

`default_nettype wire

// ---- sim/sdst_ctrl_test.sv ----
// Self-checking bench for the self refresh controller
`timescale 1ns/1ps
`default_nettype none

module sdst_ctrl_test;
  logic CLK, RESETN, REQ_VALID, REQ_READY, SD_CLK, SELF_REFRESH;
  logic REFRESH_BUSY, in_sr;
  sdst_pkg::sdst_req_s REQ;
  sdst_pkg::sdst_pins_s SD_PINS;
  int n_errors, n_compared, n_ref, n_sr, n_bad, n0;
  time t_take, t_a;
  wire [18:0] pv = {SD_PINS.cmd, SD_PINS.ba, SD_PINS.addr};

  // Short refresh window: 40 cycles between refreshes
  sdst_ctrl #(.REF_WINDOW_NS(16384000), .CLK_STABLE_CYC(2)) DUT (
    .CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ(REQ), .SD_CLK(SD_CLK),
    .SD_PINS(SD_PINS), .SELF_REFRESH(SELF_REFRESH),
    .REFRESH_BUSY(REFRESH_BUSY));
  sdst_mem_model mem (.sd_clk(SD_CLK), .pins(SD_PINS), .n_ref(n_ref),
    .n_sr(n_sr), .n_bad(n_bad), .in_sr(in_sr));

  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  task automatic chk(input string what, input logic [19:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Held until taken; refresh duty may stall it a while
  task automatic send(input sdst_pkg::sdst_kind_e k, input logic [1:0] b,
    input logic [12:0] a);
    int i;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{k, b, a};
    i = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1 && i < 400)
    begin
      @(negedge CLK);
      i++;
    end
    if (i >= 400)
    begin
      n_errors++;
      $display("unexpected request %0d: expected taken seen refused", k);
    end
    @(posedge CLK);
    t_take = $time;
    REQ_VALID <= 1'b0;
    @(negedge CLK);
  endtask

  task automatic wait_low(input bit sr);
    int i;
    i = 0;
    while ((sr ? SELF_REFRESH : REFRESH_BUSY) !== 1'b0 && i < 200)
    begin
      @(negedge CLK);
      i++;
    end
    if (i >= 200)
    begin
      n_errors++;
      $display("unexpected flag wait: expected low seen high");
    end
    repeat (2) @(negedge CLK);
  endtask

  task automatic t_wake;
    @(negedge CLK);
    chk("user refused", 20'(REQ_READY), 20'h0);
    chk("sr flag idle", 20'(SELF_REFRESH), 20'h0);
    wait_low(1'b0);
    chk("wake refs", 20'(n_ref), 20'd2);
  endtask

  task automatic t_act_rw;
    send(sdst_pkg::K_ACT, 2'h1, 13'h0123);
    t_a = t_take;
    chk("act", 20'(pv), 20'({4'h3, 2'h1, 13'h0123}));
    send(sdst_pkg::K_READ, 2'h1, 13'h1555);
    chk("read", 20'(pv), 20'({4'h5, 2'h1, 13'h1155}));
    chk("rcd", 20'(t_take - t_a >= 20), 20'd1);
    send(sdst_pkg::K_WRITE, 2'h1, 13'h0404);
    chk("write", 20'(pv), 20'({4'h4, 2'h1, 13'h0004}));
    send(sdst_pkg::K_PRE, 2'h1, 13'h0000);
    chk("pre", 20'(pv[18:13]), 20'({4'h2, 2'h1}));
    chk("ras", 20'(t_take - t_a >= 50), 20'd1);
  endtask

  task automatic t_banks;
    send(sdst_pkg::K_ACT, 2'h0, 13'h0001);
    t_a = t_take;
    send(sdst_pkg::K_ACT, 2'h2, 13'h1FFF);
    chk("act b", 20'(pv), 20'({4'h3, 2'h2, 13'h1FFF}));
    chk("rrd", 20'(t_take - t_a >= 20), 20'd1);
    send(sdst_pkg::K_PRE_ALL, 2'h0, 13'h0000);
    chk("pre all", 20'({SD_PINS.cmd, SD_PINS.addr[10]}), 20'h5);
    send(sdst_pkg::K_ACT, 2'h3, 13'h0002);
    t_a = t_take;
    send(sdst_pkg::K_PRE, 2'h3, 13'h0000);
    send(sdst_pkg::K_ACT, 2'h3, 13'h0003);
    chk("rc", 20'(t_take - t_a >= 70), 20'd1);
    send(sdst_pkg::K_PRE, 2'h3, 13'h0000);
  endtask

  task automatic t_sr;
    send(sdst_pkg::K_SR_ENTER, 2'h0, 13'h0000);
    chk("entry", 20'({SD_PINS.cke, SD_PINS.cmd}), 20'h01);
    repeat (20) @(negedge CLK);
    chk("in sr", 20'(in_sr), 20'h1);
    chk("sr flag", 20'(SELF_REFRESH), 20'h1);
    chk("hold refused", 20'(REQ_READY), 20'h0);
    chk("clk stopped", 20'(SD_CLK), 20'h0);
    chk("own refresh", 20'(n_sr > 0), 20'd1);
    n0 = n_ref;
    send(sdst_pkg::K_SR_EXIT, 2'h0, 13'h0000);
    wait_low(1'b1);
    chk("owed", 20'(REFRESH_BUSY), 20'h1);
    wait_low(1'b0);
    chk("exit refs", 20'(n_ref - n0), 20'd2);
    chk("out of sr", 20'(in_sr), 20'h0);
    chk("exit nops", 20'(n_bad), 20'd0);
  endtask

  task automatic t_periodic;
    n0 = n_ref;
    repeat (400) @(negedge CLK);
    chk("periodic", 20'(n_ref - n0 >= 9), 20'd1);
  endtask

  initial
  begin
    n_errors = 0;
    n_compared = 0;
    RESETN = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    t_wake();
    t_act_rw();
    t_banks();
    t_sr();
    t_periodic();
    wrap_up();
  end

  initial
  begin
    #400000;
    n_errors++;
    $display("unexpected watchdog: expected end seen hang");
    wrap_up();
  end
endmodule // sdst_ctrl_test

bind sdst_ctrl sdst_ctrl_properties #(.REF_WINDOW_NS(REF_WINDOW_NS),
  .CLK_STABLE_CYC(CLK_STABLE_CYC)) u_chk (.CLK(CLK), .RESETN(RESETN),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
  .SD_CLK(SD_CLK), .SD_PINS(SD_PINS), .SELF_REFRESH(SELF_REFRESH),
  .REFRESH_BUSY(REFRESH_BUSY));

`default_nettype wire
